// ### rtl/pdsslv_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pdsslv_consts.vh"
module pdsslv_top #(
	parameter MEM_AW = 8
) (
	input wire clk_sys_in,
	input wire rst_b_in,
	input wire scl_in,
	input wire sda_in,
	output reg sda_out,
	output reg sda_oe_out,
	input wire select_strap_bit2_in,
	input wire select_strap_bit1_in,
	input wire select_strap_bit0_in,
	input wire write_control_input_b_in,
	output reg standby_out,
	output reg selected_out,
	output reg prot_set_out
);
	// ==========================================================
	// state encoding
	localparam S_IDLE = 7'h01;
	localparam S_DEV = 7'h02;
	localparam S_ACK = 7'h04;
	localparam S_WRX = 7'h08;
	localparam S_RTX = 7'h10;
	localparam S_RACK = 7'h20;
	localparam S_WAIT = 7'h40;

	// ==========================================================
	// input synchronisers
	reg [1:0] scl_sy_r;
	reg [1:0] sda_sy_r;
	reg [1:0] wc_sy_r;
	reg [2:0] strap_a_r;
	reg [2:0] strap_b_r;
	reg scl_d_r;
	reg sda_d_r;
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scl_sy_r <= 2'h3;
			sda_sy_r <= 2'h3;
			wc_sy_r <= 2'h3;
			strap_a_r <= 3'h0;
			strap_b_r <= 3'h0;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_sy_r <= {scl_sy_r[0], scl_in};
			sda_sy_r <= {sda_sy_r[0], sda_in};
			wc_sy_r <= {wc_sy_r[0], write_control_input_b_in};
			strap_a_r <= {select_strap_bit2_in, select_strap_bit1_in, select_strap_bit0_in};
			strap_b_r <= strap_a_r;
			scl_d_r <= scl_sy_r[1];
			sda_d_r <= sda_sy_r[1];
		end
	end
	wire scl_s = scl_sy_r[1];
	wire sda_s = sda_sy_r[1];
	wire scl_rise = scl_s & ~scl_d_r;
	wire scl_fall = ~scl_s & scl_d_r;
	// data edges while clock stays high mark start and stop
	wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
	wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

	// ==========================================================
	// storage
	reg [7:0] mem [0:(1<<MEM_AW)-1];
	reg prot_r;

	function sel_ok;
		input [7:0] b;
		input [2:0] strap;
		begin
			sel_ok = (b[`PDSSLV_SEL_MSB:`PDSSLV_SEL_LSB] == strap);
		end
	endfunction

	function type_is_prot;
		input [3:0] t;
		begin
			type_is_prot = (t == `PDSSLV_PROT_TYPE);
		end
	endfunction

	// only the array and the protection register answer; other types are ignored
	function type_known;
		input [3:0] t;
		begin
			type_known = (t == `PDSSLV_MEM_TYPE) || type_is_prot(t);
		end
	endfunction

	// ==========================================================
	// protocol engine
	reg [6:0] state_r;
	reg [7:0] shift_r;
	reg [3:0] bit_r;
	reg rw_r;
	reg is_prot_r;
	reg addr_phase_r;
	reg [MEM_AW-1:0] addr_r;
	reg [4:0] page_cnt_r;
	reg ack_go_r;
	reg [7:0] tx_r;
	reg fifo_push;
	reg [MEM_AW-1:0] wr_addr_r;

	wire fifo_ready;
	wire fifo_valid;
	wire [MEM_AW+7:0] fifo_data;
	wire fifo_flush = 1'b0;

	// write data waits in the fifo; full fifo refuses the byte
	pdsslv_fifo #(
		.WIDTH(MEM_AW + 8),
		.DEPTH(`PDSSLV_FIFO_DEPTH),
		.AW(`PDSSLV_FIFO_AW)
	) u_fifo (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.flush_in(fifo_flush),
		.in_valid_in(fifo_push),
		.in_ready_out(fifo_ready),
		.in_data_in({wr_addr_r, shift_r}),
		.out_valid_out(fifo_valid),
		.out_ready_in(1'b1),
		.out_data_out(fifo_data)
	);

	always @(posedge clk_sys_in) begin
		if (fifo_valid)
			mem[fifo_data[MEM_AW+7:8]] <= fifo_data[7:0];
	end

	wire [7:0] rd_byte = is_prot_r ? {7'h00, prot_r} : mem[addr_r];
	wire [3:0] dev_type = shift_r[`PDSSLV_TYPE_MSB:`PDSSLV_TYPE_LSB];

	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= S_IDLE;
			shift_r <= 8'h00;
			bit_r <= 4'h0;
			rw_r <= 1'b0;
			is_prot_r <= 1'b0;
			addr_phase_r <= 1'b0;
			addr_r <= {MEM_AW{1'b0}};
			wr_addr_r <= {MEM_AW{1'b0}};
			page_cnt_r <= 5'h00;
			ack_go_r <= 1'b0;
			tx_r <= 8'h00;
			fifo_push <= 1'b0;
			prot_r <= `PDSSLV_PROT_RST;
			sda_out <= 1'b0;
			sda_oe_out <= 1'b0;
			standby_out <= 1'b1;
			selected_out <= 1'b0;
			prot_set_out <= `PDSSLV_PROT_RST;
		end else begin
			fifo_push <= 1'b0;
			prot_set_out <= prot_r;
			standby_out <= (state_r == S_IDLE);
			selected_out <= (state_r != S_IDLE) && (state_r != S_DEV);
			if (stop_det) begin
				state_r <= S_IDLE;
				sda_oe_out <= 1'b0;
			end else if (start_det) begin
				// repeated start keeps the address pointer
				state_r <= S_DEV;
				bit_r <= 4'h0;
				sda_oe_out <= 1'b0;
			end else begin
				case (state_r)
				S_IDLE: begin
					sda_oe_out <= 1'b0;
				end
				S_DEV, S_WRX: begin
					// sample on rising clock, msb first
					if (scl_rise) begin
						shift_r <= {shift_r[6:0], sda_s};
						bit_r <= bit_r + 4'h1;
					end else if (scl_fall && bit_r == `PDSSLV_BYTE_BITS) begin
						bit_r <= 4'h0;
						if (state_r == S_DEV) begin
							if (type_known(dev_type) && sel_ok(shift_r, strap_b_r)) begin
								is_prot_r <= type_is_prot(dev_type);
								rw_r <= shift_r[`PDSSLV_RW_BIT];
								addr_phase_r <= ~shift_r[`PDSSLV_RW_BIT];
								page_cnt_r <= 5'h00;
								ack_go_r <= 1'b1;
								sda_out <= 1'b0;
								sda_oe_out <= 1'b1;
								state_r <= S_ACK;
							end else begin
								state_r <= S_IDLE;
							end
						end else begin
							ack_go_r <= 1'b1;
							sda_out <= 1'b0;
							sda_oe_out <= fifo_ready;
							state_r <= S_ACK;
							if (addr_phase_r) begin
								addr_r <= shift_r[MEM_AW-1:0];
								addr_phase_r <= 1'b0;
							end else if (!wc_sy_r[1] && fifo_ready
								&& page_cnt_r < `PDSSLV_PAGE_MAX) begin
								if (is_prot_r) begin
									prot_r <= 1'b1;
								end else begin
									wr_addr_r <= addr_r;
									fifo_push <= 1'b1;
									addr_r[3:0] <= addr_r[3:0] + 4'h1;
								end
								page_cnt_r <= page_cnt_r + 5'h01;
							end
						end
					end
				end
				S_ACK: begin
					// ack held through the ninth clock
					if (scl_fall) begin
						sda_oe_out <= 1'b0;
						ack_go_r <= 1'b0;
						if (rw_r) begin
							tx_r <= {rd_byte[6:0], 1'b0};
							sda_out <= rd_byte[7];
							sda_oe_out <= ~rd_byte[7];
							addr_r <= addr_r + 1'b1;
							bit_r <= 4'h1;
							state_r <= S_RTX;
						end else begin
							state_r <= S_WRX;
						end
					end
				end
				S_RTX: begin
					// open drain: drive only zeros
					if (scl_fall) begin
						if (bit_r == `PDSSLV_BYTE_BITS) begin
							sda_oe_out <= 1'b0;
							state_r <= S_RACK;
						end else begin
							sda_out <= tx_r[7];
							sda_oe_out <= ~tx_r[7];
							tx_r <= {tx_r[6:0], 1'b0};
							bit_r <= bit_r + 4'h1;
						end
					end
				end
				S_RACK: begin
					if (scl_rise) begin
						if (!sda_s)
							state_r <= S_ACK;
						else
							state_r <= S_WAIT;
					end
				end
				S_WAIT: begin
					sda_oe_out <= 1'b0;
				end
				default: begin
					state_r <= S_IDLE;
					sda_oe_out <= 1'b0;
				end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/pdsslv_consts.vh
`ifndef PDSSLV_CONSTS_VH
`define PDSSLV_CONSTS_VH
`define PDSSLV_MEM_TYPE 4'h5
`define PDSSLV_PROT_TYPE 4'h3
`define PDSSLV_TYPE_MSB 7
`define PDSSLV_TYPE_LSB 4
`define PDSSLV_SEL_MSB 3
`define PDSSLV_SEL_LSB 1
`define PDSSLV_RW_BIT 0
`define PDSSLV_BYTE_BITS 4'h8
`define PDSSLV_PAGE_MAX 5'h10
`define PDSSLV_PAGE_MASK 8'h0f
`define PDSSLV_FIFO_DEPTH 16
`define PDSSLV_FIFO_AW 4
`define PDSSLV_PROT_RST 1'b0
`endif

// ### rtl/pdsslv_fifo.v
`timescale 1ns/1ps
`default_nettype none
module pdsslv_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	input wire clk_sys_in,
	input wire rst_b_in,
	input wire flush_in,
	input wire in_valid_in,
	output wire in_ready_out,
	input wire [WIDTH-1:0] in_data_in,
	output wire out_valid_out,
	input wire out_ready_in,
	output wire [WIDTH-1:0] out_data_out
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_r;
	reg [AW-1:0] rd_ptr_r;
	reg [AW:0] count_r;
	wire push;
	wire pop;
	assign in_ready_out = (count_r != DEPTH);
	assign out_valid_out = (count_r != 0);
	assign out_data_out = mem[rd_ptr_r];
	assign push = in_valid_in & in_ready_out;
	assign pop = out_valid_out & out_ready_in;
	always @(posedge clk_sys_in) begin
		if (push)
			mem[wr_ptr_r] <= in_data_in;
	end
	always @(posedge clk_sys_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else if (flush_in) begin
			wr_ptr_r <= {AW{1'b0}};
			rd_ptr_r <= {AW{1'b0}};
			count_r <= {(AW+1){1'b0}};
		end else begin
			if (push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (push & ~pop)
				count_r <= count_r + 1'b1;
			else if (pop & ~push)
				count_r <= count_r - 1'b1;
		end
	end
endmodule
`default_nettype wire

// ### sim/pdsslv_props.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// bus checks
module pdsslv_props (
	input wire logic clk_sys_in,
	input wire logic rst_b_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic write_control_input_b_in,
	input wire logic standby_out,
	input wire logic selected_out,
	input wire logic prot_set_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_b_in);
	sequence start_s;
		scl_in && $past(scl_in) && $fell(sda_in);
	endsequence
	sequence stop_s;
		scl_in && $past(scl_in) && $rose(sda_in);
	endsequence
	chk_pull_only: assert property (sda_oe_out |-> !sda_out)
		else $error("data driven high");
	chk_edge_low: assert property ($changed(sda_oe_out) |-> !scl_in)
		else $error("data moved with clock high");
	chk_stop_idle: assert property (stop_s |-> ##[1:8] standby_out)
		else $error("no standby after stop");
	chk_stop_free: assert property (stop_s |-> ##[1:8] !selected_out)
		else $error("still selected after stop");
	chk_idle_quiet: assert property (standby_out |-> !sda_oe_out)
		else $error("driving while idle");
	chk_start_wake: assert property (start_s |-> ##[1:8] !standby_out)
		else $error("start not seen");
	chk_bit_hold: assert property ($rose(sda_oe_out) |-> sda_oe_out [*6])
		else $error("low level too short");
	chk_prot_gate: assert property ($rose(prot_set_out) |-> !write_control_input_b_in)
		else $error("protect set while barred");
endmodule
`default_nettype wire

// ### sim/pdsslv_mst.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// two-wire master
module pdsslv_mst (
	output logic scl_out,
	output logic sda_low_out,
	input wire logic sda_in
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic bit_io(input logic b, output logic s);
		#16 sda_low_out = ~b;
		#16 scl_out = 1'b1;
		#16 s = sda_in;
		#16 scl_out = 1'b0;
	endtask
	task automatic start();
		#16 sda_low_out = 1'b0;
		#16 scl_out = 1'b1;
		#16 sda_low_out = 1'b1;
		#16 scl_out = 1'b0;
	endtask
	task automatic stop();
		#16 sda_low_out = 1'b1;
		#16 scl_out = 1'b1;
		#16 sda_low_out = 1'b0;
		#16;
	endtask
	task automatic wr(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic rd(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
		bit_io(last, s);
	endtask
endmodule
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ========
// bench
module tb_top;
	logic clk_sys_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic [2:0] strap = 3'b101;
	logic wr_ctl_b = 1'b0;
	logic scl, m_low, sda_oe, sda_drv, standby, selected, prot, ack;
	logic [7:0] d;
	int error_cnt = 0;
	int checks = 0;
	// strap, select byte, acknowledge expected
	logic [11:0] rows [6] = '{{3'b101, 8'h5a, 1'b1}, {3'b011, 8'h56, 1'b1},
		{3'b011, 8'h5a, 1'b0}, {3'b000, 8'h30, 1'b1}, {3'b000, 8'h70, 1'b0},
		{3'b111, 8'h3e, 1'b1}};
	wire sda = ~(m_low | (sda_oe & ~sda_drv));
	always #4 clk_sys_in = ~clk_sys_in;
	pdsslv_top pdsslv_top_i (
		.clk_sys_in(clk_sys_in),
		.rst_b_in(rst_b_in),
		.scl_in(scl),
		.sda_in(sda),
		.sda_out(sda_drv),
		.sda_oe_out(sda_oe),
		.select_strap_bit2_in(strap[2]),
		.select_strap_bit1_in(strap[1]),
		.select_strap_bit0_in(strap[0]),
		.write_control_input_b_in(wr_ctl_b),
		.standby_out(standby),
		.selected_out(selected),
		.prot_set_out(prot)
	);
	pdsslv_mst pdsslv_mst_i (
		.scl_out(scl),
		.sda_low_out(m_low),
		.sda_in(sda)
	);
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr_chk(input logic [7:0] b);
		pdsslv_mst_i.wr(b, ack);
		check("write ack", 8'(ack), 8'h01);
	endtask
	task automatic idle_chk();
		pdsslv_mst_i.stop();
		repeat (8) @(posedge clk_sys_in);
		#1 check("standby", 8'(standby), 8'h01);
	endtask
	initial begin
		#100000;
		error_cnt++;
		print_verdict();
	end
	initial begin
		repeat (16) @(posedge clk_sys_in);
		#1 check("reset", 8'({sda_oe, standby, selected, prot}), 8'h04);
		rst_b_in = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		#1;
		foreach (rows[i]) begin
			strap = rows[i][11:9];
			pdsslv_mst_i.start();
			pdsslv_mst_i.wr(rows[i][8:1], ack);
			check("select ack", 8'(ack), 8'(rows[i][0]));
			check("selected", 8'(selected), 8'(rows[i][0]));
			idle_chk();
		end
		strap = 3'b101;
		pdsslv_mst_i.start();
		wr_chk(8'h5a);
		wr_chk(8'h10);
		wr_chk(8'h3c);
		wr_chk(8'ha5);
		idle_chk();
		wr_ctl_b = 1'b1;
		pdsslv_mst_i.start();
		wr_chk(8'h5a);
		wr_chk(8'h10);
		wr_chk(8'h77);
		idle_chk();
		wr_ctl_b = 1'b0;
		pdsslv_mst_i.start();
		wr_chk(8'h5a);
		wr_chk(8'h10);
		pdsslv_mst_i.start();
		wr_chk(8'h5b);
		pdsslv_mst_i.rd(1'b0, d);
		check("read byte", d, 8'h3c);
		pdsslv_mst_i.rd(1'b1, d);
		check("next byte", d, 8'ha5);
		check("released", 8'(sda_oe), 8'h00);
		idle_chk();
		pdsslv_mst_i.start();
		wr_chk(8'h3a);
		wr_chk(8'h00);
		wr_chk(8'h01);
		idle_chk();
		check("protect flag", 8'(prot), 8'h01);
		pdsslv_mst_i.start();
		wr_chk(8'h3b);
		pdsslv_mst_i.rd(1'b1, d);
		check("protect read", d, 8'h01);
		idle_chk();
		rst_b_in = 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1 check("reset", 8'({sda_oe, standby, selected, prot}), 8'h04);
		rst_b_in = 1'b1;
		repeat (4) @(posedge clk_sys_in);
		#1;
		pdsslv_mst_i.start();
		wr_chk(8'h3b);
		pdsslv_mst_i.rd(1'b1, d);
		check("protect cleared", d, 8'h00);
		idle_chk();
		print_verdict();
	end
endmodule
bind pdsslv_top pdsslv_props pdsslv_props_i (
	.clk_sys_in(clk_sys_in),
	.rst_b_in(rst_b_in),
	.scl_in(scl_in),
	.sda_in(sda_in),
	.sda_out(sda_out),
	.sda_oe_out(sda_oe_out),
	.write_control_input_b_in(write_control_input_b_in),
	.standby_out(standby_out),
	.selected_out(selected_out),
	.prot_set_out(prot_set_out)
);
`default_nettype wire
